// [logic/ccp_consts.svh]
// Constants for the capture/compare channel block: register offsets,
// field positions, reset values and channel counts.
// Assumes a 16-bit register port with an 8-bit word address.
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define A_DISABLE 8'h00
`define A_CAP_CTRL 8'h01
`define A_CAP_DATA0 8'h02
`define A_CAP_STAT 8'h06
`define A_CMP_CTRL 8'h07
`define A_CMP_PRI0 8'h08
`define A_CMP_SEC0 8'h0c
`define A_INT_STAT 8'h10
`define A_INT_MASK 8'h11

// ----------------------------------------------------------------------
// Field positions, widths and reset values
// ----------------------------------------------------------------------
`define DIS_CAP_LSB 8
`define DIS_CMP_LSB 0
`define DIS_MASK 16'h0f0f
`define DIS_RESET 16'h0000
`define CAP_CTRL_W 11
`define CMP_CTRL_W 5
`define VALUE_RESET 16'h0000
`define INT_RESET 8'h00

// ----------------------------------------------------------------------
// Channel counts and source counts
// ----------------------------------------------------------------------
`define CHAN_N 4
`define CAP_DEPTH 3'h4
`define CAP_CLK_N 3'h6
`define CMP_CLK_N 3'h7
`define SYNC_SRC_N 5'h13

`endif

// [logic/ccp_pkg.sv]
// Types shared by the capture/compare block: control layouts and modes.
// Assumes ccp_consts.svh is on the include path.
package ccp_pkg;

  // Compare operating mode
  typedef enum logic [1:0] {CMP_OFF, CMP_TOGGLE, CMP_SINGLE, CMP_CONT} cmp_mode_t;

  // Capture control: [10:9] cascade pairs, [8:6] clock, [5:1] source, [0] trigger
  typedef struct packed {
    logic [1:0] cascade;
    logic [2:0] clk_sel;
    logic [4:0] src_sel;
    logic trig;
  } cap_ctrl_t;

  // Compare control: [4:3] mode, [2:0] clock
  typedef struct packed {
    cmp_mode_t mode;
    logic [2:0] clk_sel;
  } cmp_ctrl_t;

  // One register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] data;
  } bus_req_t;

endpackage

// [logic/capture_channel.sv]
// One capture channel: a 16-bit counter and a four-entry value store.
// Assumes all strobes are synchronous to clk and one cycle long.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_consts.svh"

module capture_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic hold,
  input wire logic tick,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  // State
  output logic [15:0] count,
  output logic [15:0] head,
  output logic not_empty,
  output logic full,
  output logic carry
);

  logic [15:0] mem [4];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] level;
  logic do_push;
  logic do_pop;

  // Store accepts only with room, so an overflow drops the newest value
  assign do_push = push && (level != `CAP_DEPTH);
  assign do_pop = pop && (level != 3'h0);
  assign head = mem[rd_ptr];
  assign not_empty = (level != 3'h0);
  assign full = (level == `CAP_DEPTH);
  assign carry = !hold && !clear && tick && (count == 16'hffff);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Clear wins over the tick so a sync source restarts the count at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
    end else if (hold || clear) begin
      count <= 16'h0000;
    end else if (tick) begin
      count <= count + 16'h0001; // RL8
    end
  end

  // ----------------------------------------------------------------------
  // Value store
  // ----------------------------------------------------------------------
  // Held channel drops every stored value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      level <= 3'h0;
    end else if (hold) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      level <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 2'h1; // RL7
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      level <= level + {2'h0, do_push} - {2'h0, do_pop};
    end
  end

  // Entries carry no reset; they are never read while empty
  always_ff @(posedge clk) begin
    if (do_push && !hold) begin
      mem[wr_ptr] <= count;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_count_step;
    (!hold && !clear && tick) |=> (count == $past(count) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step"); // RL8

  property p_store_full;
    (!hold && push && !pop && full) |=> (full && head == $past(head));
  endproperty
  a_store_full: assert property (p_store_full) else $error("full store changed"); // RL7

endmodule // capture_channel
`default_nettype wire

// [logic/ccp_top.sv]
// Four input capture and four output compare channels with a
// per-channel disable register, interrupt status and DMA requests.
// Assumes a synchronous register port and synchronous pin inputs on MCLK.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_consts.svh"

// Overview of operation
// RL1 - Capture disable bit set holds capture channel off
// RL2 - Compare disable bits 3..0 hold compare channels off
// RL3 - Compare disable bit clear lets channel run
// RL4 - Four independent capture channels exist
// RL5 - Adjacent capture pairs cascade into 32 bits
// RL6 - Sync or trigger from one of 19 sources
// RL7 - Each capture channel keeps four-entry value store
// RL8 - Own 16-bit counter, six selectable clocks
// RL9 - Compare time base from seven clocks
// RL10 - Compare uses one or two registers
// RL11 - Match changes the compare pin level
// RL12 - Single pulse or continuous pulse train
// RL13 - Match raises interrupt and DMA request
// RL14 - Disabled channel is reset, ignores events
module ccp_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WR_DATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RD_DATA,
  // Clock-source enables and sync sources
  input wire logic [5:0] TICK,
  input wire logic [18:0] SYNC,
  // Pins
  input wire logic [3:0] CAP_PIN,
  output logic [3:0] CMP_PIN,
  // Events
  output logic [3:0] DMA_REQ,
  output logic IRQ
);

  ccp_pkg::bus_req_t req;
  logic [15:0] dis;
  ccp_pkg::cap_ctrl_t cap_ctrl;
  ccp_pkg::cmp_ctrl_t cmp_ctrl;
  logic [15:0] cmp_pri [4];
  logic [15:0] cmp_sec [4];
  logic [7:0] int_stat;
  logic [7:0] int_mask;
  logic [3:0] cap_ovf;
  logic [3:0] cap_off;
  logic [3:0] cmp_off;
  logic [6:0] src7;
  logic cap_tick_base;
  logic cmp_tick;
  logic sync_hit;
  logic [3:0] pin_prev;
  logic [3:0] rise;
  logic [3:0] armed;
  logic [3:0] cap_tick;
  logic [3:0] cap_clr;
  logic [3:0] cap_push;
  logic [3:0] cap_pop;
  logic [3:0] cap_ne;
  logic [3:0] cap_full;
  logic [3:0] cap_carry;
  logic [15:0] cap_count [4];
  logic [15:0] cap_head [4];
  logic [15:0] cmp_timer [4];
  logic [3:0] cmp_done;
  logic [3:0] hit_pri;
  logic [3:0] hit_sec;
  logic [7:0] next_int_stat;
  logic [15:0] next_rd_data;

  // Selects one enable; a reserved selector gives no tick at all
  function automatic logic pick_tick(input logic [6:0] v, input logic [2:0] sel, input logic [2:0] n);
    pick_tick = (sel < n) ? v[sel] : 1'b0;
  endfunction

  // Tells whether an access hits a register
  function automatic logic hit(input ccp_pkg::bus_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  assign req = '{wr: WR, rd: RD, addr: ADDR, data: WR_DATA};
  assign cap_off = dis[`DIS_CAP_LSB +: 4];
  assign cmp_off = dis[`DIS_CMP_LSB +: 4];

  // ----------------------------------------------------------------------
  // Software configuration
  // ----------------------------------------------------------------------
  // Unimplemented disable bits are masked so they always read zero
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dis <= `DIS_RESET;
      cap_ctrl <= '0;
      cmp_ctrl <= '0;
      int_mask <= `INT_RESET;
      for (int i = 0; i < `CHAN_N; i++) begin
        cmp_pri[i] <= `VALUE_RESET;
        cmp_sec[i] <= `VALUE_RESET;
      end
    end else if (req.wr) begin
      if (hit(req, `A_DISABLE)) dis <= req.data & `DIS_MASK; // RL1 RL2
      if (hit(req, `A_CAP_CTRL)) cap_ctrl <= ccp_pkg::cap_ctrl_t'(req.data[`CAP_CTRL_W-1:0]);
      if (hit(req, `A_CMP_CTRL)) cmp_ctrl <= ccp_pkg::cmp_ctrl_t'(req.data[`CMP_CTRL_W-1:0]);
      if (hit(req, `A_INT_MASK)) int_mask <= req.data[7:0];
      for (int i = 0; i < `CHAN_N; i++) begin
        if (hit(req, `A_CMP_PRI0 + 8'(i))) cmp_pri[i] <= req.data;
        if (hit(req, `A_CMP_SEC0 + 8'(i))) cmp_sec[i] <= req.data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock sources and sync selection
  // ----------------------------------------------------------------------
  // Source 0 runs at MCLK, sources 1..6 are the external enables
  assign src7 = {TICK, 1'b1};
  assign cap_tick_base = pick_tick(src7, cap_ctrl.clk_sel, `CAP_CLK_N); // RL8
  assign cmp_tick = pick_tick(src7, cmp_ctrl.clk_sel, `CMP_CLK_N); // RL9
  assign sync_hit = (cap_ctrl.src_sel < `SYNC_SRC_N) ? SYNC[cap_ctrl.src_sel] : 1'b0; // RL6

  // ----------------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------------
  // Rising pin edges; inputs are already synchronous to MCLK
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_prev <= 4'h0;
    end else begin
      pin_prev <= CAP_PIN;
    end
  end
  assign rise = CAP_PIN & ~pin_prev;

  // Trigger mode keeps the counter at zero until the source fires once
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      armed <= 4'h0;
    end else begin
      for (int i = 0; i < `CHAN_N; i++) begin
        if (cap_off[i] || !cap_ctrl.trig) begin
          armed[i] <= 1'b0;
        end else if (sync_hit) begin
          armed[i] <= 1'b1; // RL6
        end
      end
    end
  end

  // A cascaded upper channel counts on the lower carry and captures on the lower pin
  always_comb begin
    for (int i = 0; i < `CHAN_N; i++) begin
      cap_tick[i] = cap_tick_base;
      cap_clr[i] = cap_ctrl.trig ? !armed[i] : sync_hit;
      cap_push[i] = rise[i] && !cap_off[i]; // RL14
      cap_pop[i] = req.rd && hit(req, `A_CAP_DATA0 + 8'(i));
    end
    for (int i = 1; i < `CHAN_N; i += 2) begin
      if (cap_ctrl.cascade[i/2]) begin
        cap_tick[i] = cap_carry[i-1]; // RL5
        cap_clr[i] = cap_clr[i-1];
        cap_push[i] = rise[i-1] && !cap_off[i];
      end
    end
  end

  generate
    for (genvar g = 0; g < `CHAN_N; g++) begin : g_cap
      capture_channel u_cap ( // RL4
        .clk(MCLK),
        .rst(RST),
        .hold(cap_off[g]), // RL1
        .tick(cap_tick[g]),
        .clear(cap_clr[g]),
        .push(cap_push[g]),
        .pop(cap_pop[g]),
        .count(cap_count[g]),
        .head(cap_head[g]),
        .not_empty(cap_ne[g]),
        .full(cap_full[g]),
        .carry(cap_carry[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------------
  // Toggle mode looks at the primary value only; pulse modes use both
  always_comb begin
    for (int i = 0; i < `CHAN_N; i++) begin
      hit_pri[i] = !cmp_off[i] && cmp_ctrl.mode != ccp_pkg::CMP_OFF && !cmp_done[i] && cmp_tick
                   && cmp_timer[i] == cmp_pri[i]; // RL3 RL10
      hit_sec[i] = !cmp_off[i] && cmp_ctrl.mode != ccp_pkg::CMP_OFF && !cmp_done[i] && cmp_tick
                   && cmp_ctrl.mode != ccp_pkg::CMP_TOGGLE && cmp_timer[i] == cmp_sec[i]; // RL10
    end
  end

  // Secondary match wins over primary so equal values end the pulse
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CMP_PIN <= 4'h0;
      cmp_done <= 4'h0;
      for (int i = 0; i < `CHAN_N; i++) cmp_timer[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < `CHAN_N; i++) begin
        if (cmp_off[i] || cmp_ctrl.mode == ccp_pkg::CMP_OFF) begin
          cmp_timer[i] <= 16'h0000; // RL2 RL14
          CMP_PIN[i] <= 1'b0;
          cmp_done[i] <= 1'b0;
        end else begin
          // Rewriting the mode re-arms a single pulse; a match in that cycle still acts and its stop wins
          if (req.wr && hit(req, `A_CMP_CTRL)) cmp_done[i] <= 1'b0;
          if (cmp_tick && !cmp_done[i]) begin
            case (cmp_ctrl.mode)
              ccp_pkg::CMP_TOGGLE: begin
                cmp_timer[i] <= cmp_timer[i] + 16'h0001;
                if (hit_pri[i]) CMP_PIN[i] <= ~CMP_PIN[i]; // RL11
              end
              ccp_pkg::CMP_SINGLE, ccp_pkg::CMP_CONT: begin
                if (hit_sec[i]) begin
                  CMP_PIN[i] <= 1'b0; // RL12
                  cmp_timer[i] <= 16'h0000;
                  cmp_done[i] <= (cmp_ctrl.mode == ccp_pkg::CMP_SINGLE);
                end else begin
                  cmp_timer[i] <= cmp_timer[i] + 16'h0001;
                  if (hit_pri[i]) CMP_PIN[i] <= 1'b1; // RL11
                end
              end
              default: begin
                cmp_timer[i] <= 16'h0000;
              end
            endcase
          end
        end
      end
    end
  end

  // DMA request is a one-cycle pulse per match event
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      DMA_REQ <= 4'h0;
    end else begin
      DMA_REQ <= hit_pri | hit_sec; // RL13
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and overflow flags
  // ----------------------------------------------------------------------
  // New events win over the clear that a status read causes
  always_comb begin
    next_int_stat = int_stat;
    if (req.rd && hit(req, `A_INT_STAT)) next_int_stat = 8'h00;
    next_int_stat = next_int_stat | {hit_pri | hit_sec, cap_push}; // RL13
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      int_stat <= `INT_RESET;
      IRQ <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      IRQ <= |(int_stat & int_mask); // RL13
    end
  end

  // Overflow marks a push to a full store in a cycle where no read pops that store
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cap_ovf <= 4'h0;
    end else begin
      cap_ovf <= ((req.rd && hit(req, `A_CAP_STAT)) ? 4'h0 : cap_ovf) | (cap_push & cap_full & ~cap_pop);
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Unmapped addresses read zero
  always_comb begin
    next_rd_data = 16'h0000;
    case (req.addr)
      `A_DISABLE: next_rd_data = dis;
      `A_CAP_CTRL: next_rd_data = {5'h00, cap_ctrl};
      `A_CAP_STAT: next_rd_data = {8'h00, cap_ovf, cap_ne};
      `A_CMP_CTRL: next_rd_data = {11'h000, cmp_ctrl};
      `A_INT_STAT: next_rd_data = {8'h00, int_stat};
      `A_INT_MASK: next_rd_data = {8'h00, int_mask};
      default: begin
        for (int i = 0; i < `CHAN_N; i++) begin
          if (hit(req, `A_CAP_DATA0 + 8'(i))) next_rd_data = cap_ne[i] ? cap_head[i] : 16'h0000;
          if (hit(req, `A_CMP_PRI0 + 8'(i))) next_rd_data = cmp_pri[i];
          if (hit(req, `A_CMP_SEC0 + 8'(i))) next_rd_data = cmp_sec[i];
        end
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RD_DATA <= 16'h0000;
    end else begin
      RD_DATA <= req.rd ? next_rd_data : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_match0;
    !cmp_off[0] && cmp_ctrl.mode == ccp_pkg::CMP_TOGGLE && cmp_tick && !cmp_done[0]
    && cmp_timer[0] == cmp_pri[0];
  endsequence

  sequence s_single_end0;
    cmp_ctrl.mode == ccp_pkg::CMP_SINGLE && hit_sec[0] && !(req.wr && hit(req, `A_CMP_CTRL));
  endsequence

  property p_cap_off;
    1'b1 |-> ((cap_ne & cap_off & $past(cap_off)) == 4'h0);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("disabled capture holds data"); // RL1

  property p_cmp_off;
    1'b1 |-> ((CMP_PIN & cmp_off & $past(cmp_off)) == 4'h0);
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("disabled compare pin high"); // RL2

  property p_match_dma;
    s_match0 |=> DMA_REQ[0];
  endproperty
  a_match_dma: assert property (p_match_dma) else $error("enabled match gave no request"); // RL3

  property p_toggle;
    s_match0 |=> (CMP_PIN[0] != $past(CMP_PIN[0]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle on match"); // RL11

  property p_single;
    s_single_end0 |=> (!CMP_PIN[0] && cmp_done[0]) ##1 !DMA_REQ[0];
  endproperty
  a_single: assert property (p_single) else $error("single pulse did not stop"); // RL12

  property p_irq;
    (DMA_REQ[0] && int_mask[4]) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked match gave no interrupt"); // RL13

  property p_cascade;
    (cap_ctrl.cascade[0] && cap_push[0] && !cap_off[1]) |-> cap_push[1];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascaded pair split capture"); // RL5

  property p_sync;
    (!cap_ctrl.trig && sync_hit && !cap_off[0]) |=> (cap_count[0] == 16'h0000);
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not clear counter"); // RL6

  property p_no_dma;
    1'b1 |-> ((DMA_REQ & cmp_off & $past(cmp_off)) == 4'h0);
  endproperty
  a_no_dma: assert property (p_no_dma) else $error("disabled compare made request"); // RL14

endmodule // ccp_top
`default_nettype wire

// [tb/pin_source.sv]
// Far-side model: external pulse sources on the four capture pins.
// Assumes one-cycle go requests, synchronous to clk, changed after its edge.
`timescale 1ns/100ps
`default_nettype none

module pin_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench
  input wire logic go,
  input wire logic [3:0] mask,
  input wire logic [1:0] dly,
  // Pins
  output logic [3:0] pin
);
  // Idle low, then one high cycle after dly cycles; a slow source shows
  // that capture does not depend on when the request was made
  initial pin = 4'h0;
  always @(posedge clk) begin
    if (!rst && go) begin
      repeat (dly) @(posedge clk);
      pin <= mask;
      @(posedge clk);
      pin <= 4'h0;
    end
  end
endmodule // pin_source

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for ccp_top: register port, capture and compare.
// Assumes ccp_consts.svh on the include path and pin_source beside it.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_consts.svh"

module tb;
  // ----------------------------------------------------------------
  // Signals, model state and instances
  // ----------------------------------------------------------------
  logic mclk, rst, wr, rd, go, irq;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data;
  logic [5:0] tick;
  logic [18:0] sync;
  logic [3:0] cap_pin, cmp_pin, dma_req, mask, pe, de, st;
  logic [1:0] dly;
  int miscompares, compares, seed, cnt, n;
  int q[4][$];
  int p[4], s[4], t[4];
  ccp_pkg::cap_ctrl_t cc;

  ccp_top u_ccp_top (.MCLK(mclk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data), .WR(wr), .RD(rd),
    .RD_DATA(rd_data), .TICK(tick), .SYNC(sync), .CAP_PIN(cap_pin), .CMP_PIN(cmp_pin),
    .DMA_REQ(dma_req), .IRQ(irq));
  pin_source u_pin_source (.clk(mclk), .rst(rst), .go(go), .mask(mask), .dly(dly), .pin(cap_pin));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write strobe stands one cycle beside address and data
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rd_data, exp);
  endtask

  // One tick on clock source 1, then look once the edge has settled
  task automatic pulse_tick();
    @(posedge mclk);
    tick <= 6'h01;
    @(posedge mclk);
    tick <= 6'h00;
    @(negedge mclk);
  endtask

  // Ask the pin source for a pulse and wait out its slowest answer
  task automatic pins(input logic [3:0] m);
    @(posedge mclk);
    go <= 1'b1;
    mask <= m;
    dly <= 2'($random(seed));
    @(posedge mclk);
    go <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h2c7a;
    rst = 1'b1;
    {wr, rd, go, addr, wr_data, tick, sync, mask, dly} = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // Reset values and disable register layout
    rd_chk(`A_DISABLE, `DIS_RESET);
    chk(16'(cmp_pin), 16'h0000);
    wr_reg(`A_DISABLE, 16'hffff);
    rd_chk(`A_DISABLE, `DIS_MASK);
    rd_chk(8'h3f, 16'h0000);
    $display("test registers done");
    // Capture: ch1 held off, sync source 3 clears the counters once
    cc = '{cascade: 2'h0, clk_sel: 3'h1, src_sel: 5'h03, trig: 1'b0};
    wr_reg(`A_CAP_CTRL, 16'(cc));
    wr_reg(`A_INT_MASK, 16'h00f1);
    wr_reg(`A_DISABLE, 16'h020f);
    cnt = 0;
    for (int k = 0; k < 5; k++) begin
      if (k == 2) begin
        @(posedge mclk);
        sync <= 19'h00008;
        @(posedge mclk);
        sync <= 19'h00000;
        cnt = 0;
      end
      n = 1 + ($random(seed) & 7);
      repeat (n) pulse_tick();
      cnt += n;
      pins(4'hf);
      for (int c = 0; c < 4; c++) begin
        if (c != 1 && q[c].size() < 4) q[c].push_back(cnt);
      end
    end
    @(negedge mclk);
    chk(16'(irq), 16'h0001);
    rd_chk(`A_INT_STAT, 16'h000d);
    @(negedge mclk);
    chk(16'(irq), 16'h0000);
    rd_chk(`A_CAP_STAT, 16'h00dd);
    rd_chk(`A_CAP_STAT, 16'h000d);
    // Fifth event was dropped; an empty store reads zero
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 5; j++) begin
        rd_chk(`A_CAP_DATA0 + 8'(c), (q[c].size() > 0) ? 16'(q[c].pop_front()) : 16'h0000);
      end
    end
    $display("test capture done");
    // Compare: every mode, ch2 held off, timers restarted by the disable
    for (int m = 0; m < 4; m++) begin
      wr_reg(`A_DISABLE, 16'hffff);
      wr_reg(`A_CMP_CTRL, 16'({2'(m), 3'h1}));
      {pe, de, st} = '0;
      for (int c = 0; c < 4; c++) begin
        p[c] = 1 + ($random(seed) & 7);
        s[c] = p[c] + 1 + ($random(seed) & 7);
        t[c] = 0;
        wr_reg(`A_CMP_PRI0 + 8'(c), 16'(p[c]));
        wr_reg(`A_CMP_SEC0 + 8'(c), 16'(s[c]));
      end
      wr_reg(`A_DISABLE, 16'h0f04);
      for (int i = 0; i < 40; i++) begin
        pulse_tick();
        de = 4'h0;
        for (int c = 0; c < 4; c++) begin
          if (c == 2 || st[c] || m == 0) continue;
          if (m == 1) begin
            if (t[c] == p[c]) begin
              pe[c] = ~pe[c];
              de[c] = 1'b1;
            end
            t[c]++;
          end else if (t[c] == s[c]) begin
            pe[c] = 1'b0;
            de[c] = 1'b1;
            t[c] = 0;
            st[c] = (m == 2);
          end else begin
            if (t[c] == p[c]) begin
              pe[c] = 1'b1;
              de[c] = 1'b1;
            end
            t[c]++;
          end
        end
        chk(16'(cmp_pin), 16'(pe));
        chk(16'(dma_req), 16'(de));
      end
      if (m == 1) begin
        chk(16'(irq), 16'h0001);
        rd_chk(`A_INT_STAT, 16'h00b0);
      end
      $display("test compare mode %0d done", m);
    end
    // Trigger mode: ticks before source 3 fires are lost; cascaded upper channel captures on the lower pin
    cc = '{cascade: 2'h1, clk_sel: 3'h1, src_sel: 5'h03, trig: 1'b1};
    wr_reg(`A_CAP_CTRL, 16'(cc));
    wr_reg(`A_DISABLE, 16'h0c0f);
    repeat (3) pulse_tick();
    @(posedge mclk);
    sync <= 19'h00008;
    @(posedge mclk);
    sync <= 19'h00000;
    n = 1 + ($random(seed) & 7);
    repeat (n) pulse_tick();
    pins(4'h1);
    rd_chk(`A_CAP_STAT, 16'h0003);
    rd_chk(`A_CAP_DATA0, 16'(n));
    rd_chk(`A_CAP_DATA0 + 8'h01, 16'h0000);
    $display("test cascade and trigger done");
    close_out();
  end
endmodule // tb

`default_nettype wire
